// ==== src/pil_pkg.sv ====
// Shared constants and types for the processor interrupt collection block.
// Assumes a 64-bit system address/data bus and a 32-bit APB register port.
package pil_pkg;

    // ------------------------------------------------------------
    // Source counts and cause-word field positions
    // ------------------------------------------------------------
    localparam int NUM_HW = 5;
    localparam int NUM_SW = 2;
    localparam int CAUSE_SW_LSB = 8;
    localparam int CAUSE_HW_LSB = 10;
    localparam int CAUSE_TIMER_BIT = 15;
    localparam int PEND_W = 8;

    // ------------------------------------------------------------
    // Interrupt update address cycle fields
    // ------------------------------------------------------------
    localparam int BUS_W = 64;
    localparam int TGT_LSB = 60;
    localparam int TGT_W = 4;
    localparam int WEN_LSB = 16;
    localparam int WVAL_LSB = 0;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CAUSE = 12'h000;
    localparam logic [11:0] OFS_SOFT = 12'h004;
    localparam logic [11:0] OFS_COUNT = 12'h008;
    localparam logic [11:0] OFS_COMPARE = 12'h00C;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [4:0] HW_PEND_RST = 5'h00;
    localparam logic [1:0] SOFT_RST = 2'h0;
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] COMPARE_RST = 32'hFFFF_FFFF;

    // Register selector codes
    typedef enum logic [2:0] {
        PIL_SEL_CAUSE = 3'b000,
        PIL_SEL_SOFT = 3'b001,
        PIL_SEL_COUNT = 3'b010,
        PIL_SEL_COMPARE = 3'b011,
        PIL_SEL_NONE = 3'b100
    } pil_sel_t;

    // Decoded interrupt update cycle
    typedef struct packed {
        logic [TGT_W-1:0] target;
        logic [NUM_HW-1:0] wr_en;
        logic [NUM_HW-1:0] wr_val;
    } pil_upd_t;

endpackage

// ==== src/pil_nmi_edge.sv ====
// Edge detector for the active-low nonmaskable interrupt input.
// Assumes the input is already synchronous to mclk_i.
`timescale 1ns/100ps
module pil_nmi_edge (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // Pin and event
    input wire logic nonmaskable_irq_n_i,
    output logic nmi_pulse_o
);

    logic seen_ff;

    // Previous asserted level; reset as "not asserted"
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            seen_ff <= 1'b0;
        end else if (clk_en_i) begin
            seen_ff <= ~nonmaskable_irq_n_i;
        end
    end

    // One pulse per assertion, however long it is held
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            nmi_pulse_o <= 1'b0;
        end else if (clk_en_i) begin
            nmi_pulse_o <= ~nonmaskable_irq_n_i & ~seen_ff;
        end
    end

endmodule

// ==== src/pil_top.sv ====
// Processor interrupt collection: hardware pending bits, software bits,
// timer bit, nonmaskable event, APB view of the cause word.
// Assumes synchronous inputs and an APB master on mclk_i.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module pil_top #(
    parameter logic [1:0] DEV_NUM = 2'h0,
    parameter int COUNT_W = 32
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // System bus interrupt update cycle
    input wire logic int_req_valid_i,
    input wire logic [pil_pkg::BUS_W-1:0] sys_addr_data_bus_i,
    // Nonmaskable pin and performance counter overflows
    input wire logic nonmaskable_irq_n_i,
    input wire logic [1:0] perf_ovf_i,
    // To exception logic
    output logic [pil_pkg::PEND_W-1:0] pending_irq_bits_o,
    output logic [31:0] cause_status_o,
    output logic nmi_pulse_o,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pil_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_count
            $error("COUNT_W must be 8 to 32");
        end
    endgenerate

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic pil_pkg::pil_upd_t decode_upd(input logic [63:0] bus);
        pil_pkg::pil_upd_t u;
        u.target = bus[pil_pkg::TGT_LSB +: pil_pkg::TGT_W];
        u.wr_en = bus[pil_pkg::WEN_LSB +: pil_pkg::NUM_HW];
        u.wr_val = bus[pil_pkg::WVAL_LSB +: pil_pkg::NUM_HW];
        return u;
    endfunction

    function automatic pil_pkg::pil_sel_t reg_sel(input logic [11:0] addr);
        unique case (addr)
            pil_pkg::OFS_CAUSE: return pil_pkg::PIL_SEL_CAUSE;
            pil_pkg::OFS_SOFT: return pil_pkg::PIL_SEL_SOFT;
            pil_pkg::OFS_COUNT: return pil_pkg::PIL_SEL_COUNT;
            pil_pkg::OFS_COMPARE: return pil_pkg::PIL_SEL_COMPARE;
            default: return pil_pkg::PIL_SEL_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pil_pkg::pil_upd_t upd;
    pil_pkg::pil_sel_t sel;
    logic upd_hit;
    logic apb_wr;
    logic [pil_pkg::NUM_HW-1:0] hw_pend_ff;
    logic [pil_pkg::NUM_HW-1:0] nxt_hw_pend;
    logic [pil_pkg::NUM_SW-1:0] soft_ff;
    logic [COUNT_W-1:0] count_ff;
    logic [COUNT_W-1:0] compare_ff;
    logic timer_ff;
    logic timer_set;
    logic [31:0] prdata_ff;
    logic [31:0] rd_mux;

    assign upd = decode_upd(sys_addr_data_bus_i);
    // Target field as a mask of up to four processors
    assign upd_hit = int_req_valid_i & upd.target[DEV_NUM];
    assign sel = reg_sel(paddr_i);
    assign apb_wr = psel_i & penable_i & pwrite_i & (sel != pil_pkg::PIL_SEL_NONE);

    // ------------------------------------------------------------
    // Hardware pending bits
    // ------------------------------------------------------------
    // Only enabled bits move; the rest hold their level
    assign nxt_hw_pend = (hw_pend_ff & ~upd.wr_en) | (upd.wr_val & upd.wr_en);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hw_pend_ff <= pil_pkg::HW_PEND_RST;
        end else if (clk_en_i && upd_hit) begin
            hw_pend_ff <= nxt_hw_pend;
        end
    end

    // ------------------------------------------------------------
    // Software bits: written only through the register port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            soft_ff <= pil_pkg::SOFT_RST;
        end else if (clk_en_i && apb_wr && sel == pil_pkg::PIL_SEL_SOFT) begin
            soft_ff <= pwdata_i[pil_pkg::NUM_SW-1:0];
        end
    end

    // ------------------------------------------------------------
    // Count, compare and timer bit
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            count_ff <= pil_pkg::COUNT_RST[COUNT_W-1:0];
        end else if (clk_en_i) begin
            if (apb_wr && sel == pil_pkg::PIL_SEL_COUNT) begin
                count_ff <= pwdata_i[COUNT_W-1:0];
            end else begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            compare_ff <= pil_pkg::COMPARE_RST[COUNT_W-1:0];
        end else if (clk_en_i && apb_wr && sel == pil_pkg::PIL_SEL_COMPARE) begin
            compare_ff <= pwdata_i[COUNT_W-1:0];
        end
    end

    assign timer_set = (count_ff == compare_ff) | (|perf_ovf_i);

    // Compare write acknowledges the timer; a same-cycle set still wins
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timer_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (timer_set) begin
                timer_ff <= 1'b1;
            end else if (apb_wr && sel == pil_pkg::PIL_SEL_COMPARE) begin
                timer_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Nonmaskable event
    // ------------------------------------------------------------
    pil_nmi_edge u_nmi (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .nonmaskable_irq_n_i(nonmaskable_irq_n_i),
        .nmi_pulse_o(nmi_pulse_o)
    );

    // ------------------------------------------------------------
    // Cause word and pending vector
    // ------------------------------------------------------------
    always_comb begin
        cause_status_o = 32'h0000_0000;
        cause_status_o[pil_pkg::CAUSE_SW_LSB +: pil_pkg::NUM_SW] = soft_ff;
        cause_status_o[pil_pkg::CAUSE_HW_LSB +: pil_pkg::NUM_HW] = hw_pend_ff;
        cause_status_o[pil_pkg::CAUSE_TIMER_BIT] = timer_ff;
    end

    assign pending_irq_bits_o = {timer_ff, hw_pend_ff, soft_ff};

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (sel)
            pil_pkg::PIL_SEL_CAUSE: rd_mux = cause_status_o;
            pil_pkg::PIL_SEL_SOFT: rd_mux[pil_pkg::NUM_SW-1:0] = soft_ff;
            pil_pkg::PIL_SEL_COUNT: rd_mux[COUNT_W-1:0] = count_ff;
            pil_pkg::PIL_SEL_COMPARE: rd_mux[COUNT_W-1:0] = compare_ff;
            pil_pkg::PIL_SEL_NONE: rd_mux = 32'h0000_0000;
        endcase
    end

    // Captured in the setup cycle so the data is a flop in the access phase
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (clk_en_i && psel_i && !penable_i) begin
            prdata_ff <= pwrite_i ? 32'h0000_0000 : rd_mux;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & (sel == pil_pkg::PIL_SEL_NONE);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // Expected value taken from the raw bus bits, not from the update logic
    property p_hw_update;
        clk_en_i && upd_hit |=> hw_pend_ff ==
            (($past(hw_pend_ff) & ~$past(sys_addr_data_bus_i[20:16]))
            | ($past(sys_addr_data_bus_i[20:16]) & $past(sys_addr_data_bus_i[4:0])));
    endproperty
    a_hw_update: assert property (p_hw_update) else $error("pending update wrong");

    property p_hw_hold;
        !upd_hit |=> $stable(hw_pend_ff);
    endproperty
    a_hw_hold: assert property (p_hw_hold) else $error("pending moved untargeted");

    property p_hw_reset;
        disable iff (1'b0) sys_rst_i |=> hw_pend_ff == 5'h00 && pending_irq_bits_o == 8'h00;
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("reset left pending");

    property p_cause_hw;
        cause_status_o[14:10] == hw_pend_ff && cause_status_o[31:16] == 16'h0000;
    endproperty
    a_cause_hw: assert property (p_cause_hw) else $error("cause hw field wrong");

    property p_soft_write;
        clk_en_i && apb_wr && sel == pil_pkg::PIL_SEL_SOFT
            |=> cause_status_o[9:8] == $past(pwdata_i[1:0]);
    endproperty
    a_soft_write: assert property (p_soft_write) else $error("soft write lost");

    property p_soft_only_apb;
        !(apb_wr && sel == pil_pkg::PIL_SEL_SOFT) |=> $stable(soft_ff);
    endproperty
    a_soft_only_apb: assert property (p_soft_only_apb) else $error("soft bits moved");

    property p_timer_match;
        clk_en_i && count_ff == compare_ff |=> cause_status_o[15];
    endproperty
    a_timer_match: assert property (p_timer_match) else $error("timer not set");

    property p_timer_ovf;
        clk_en_i && perf_ovf_i != 2'b00 |=> pending_irq_bits_o[7];
    endproperty
    a_timer_ovf: assert property (p_timer_ovf) else $error("overflow not seen");

    property p_nmi_first;
        clk_en_i && !nonmaskable_irq_n_i && $past(nonmaskable_irq_n_i) && $past(clk_en_i)
            |=> nmi_pulse_o;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi missed");

    property p_nmi_once;
        clk_en_i && nmi_pulse_o && !nonmaskable_irq_n_i |=> !nmi_pulse_o;
    endproperty
    a_nmi_once: assert property (p_nmi_once) else $error("nmi repeated");

    property p_vector;
        pending_irq_bits_o == {cause_status_o[15], cause_status_o[14:10], cause_status_o[9:8]};
    endproperty
    a_vector: assert property (p_vector) else $error("vector mismatch");

    c_set_clear: cover property (upd_hit && upd.wr_en == 5'h1F ##[1:20] upd_hit && !upd.wr_val[0]);
    c_nmi_twice: cover property (nmi_pulse_o ##[2:20] nmi_pulse_o);
    c_timer: cover property (count_ff == compare_ff ##1 timer_ff);
    c_bad_addr: cover property (pslverr_o);

endmodule

// ==== verif/pil_agent.sv ====
// External agent model: interrupt update cycles and the nonmaskable pin.
// Assumes tasks are called right after a rising edge of mclk_i.
`timescale 1ns/100ps
module pil_agent (
    // Clock
    input wire logic mclk_i,
    // Bus cycle and pin
    output logic int_req_valid_o,
    output logic [63:0] sys_addr_data_bus_o,
    output logic nonmaskable_irq_n_o
);
    initial begin
        int_req_valid_o = 1'b0;
        sys_addr_data_bus_o = 64'h0;
        nonmaskable_irq_n_o = 1'b1;
    end

    // Unused bus bits set high so a sloppy decode shows up
    task automatic send(input logic [3:0] tgt, input logic [4:0] en, input logic [4:0] val,
                        input logic last);
        logic [63:0] b;
        b = 64'h0FFF_FFFF_FFE0_FFE0 | {tgt, 60'h0} | {43'h0, en, 16'h0} | {59'h0, val};
        int_req_valid_o <= 1'b1;
        sys_addr_data_bus_o <= b;
        @(posedge mclk_i);
        if (last) begin
            int_req_valid_o <= 1'b0;
            sys_addr_data_bus_o <= ~b;
        end
    endtask

    // Caller keeps each level for at least one cycle
    task automatic set_nmi(input logic lvl);
        nonmaskable_irq_n_o <= lvl;
    endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the interrupt collection block.
// Assumes the agent model in pil_agent.sv and zero-wait APB.
`timescale 1ns/100ps
module tb_top;
    logic mclk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, nmi_pulse, rq, nmi_n;
    logic clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cause;
    logic [63:0] bus;
    logic [7:0] pend;
    logic [1:0] perf_ovf;
    int n_errors, num_checks, k;

    pil_agent i_pil_agent (.mclk_i(mclk_i), .int_req_valid_o(rq),
        .sys_addr_data_bus_o(bus), .nonmaskable_irq_n_o(nmi_n));
    pil_top #(.DEV_NUM(2'h2)) i_pil_top (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .clk_en_i(clk_en), .int_req_valid_i(rq),
        .sys_addr_data_bus_i(bus), .nonmaskable_irq_n_i(nmi_n), .perf_ovf_i(perf_ovf),
        .pending_irq_bits_o(pend), .cause_status_o(cause), .nmi_pulse_o(nmi_pulse),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data is compared only for reads
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic exp_err);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            conclude();
        end
        if (!w) chk(prdata, exp);
        chk({31'h0, pslverr}, {31'h0, exp_err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic st(input logic t, input logic [4:0] h, input logic [1:0] s);
        @(posedge mclk_i);
        chk(cause, {16'h0, t, h, s, 8'h0});
        chk({24'h0, pend}, {24'h0, t, h, s});
        xfer(1'b0, pil_pkg::OFS_CAUSE, 32'h0, {16'h0, t, h, s, 8'h0}, 1'b0);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        n_errors = 0;
        num_checks = 0;
        sys_rst_i = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        perf_ovf = 2'h0;
        clk_en = 1'b1;
        repeat (6) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        st(1'b0, 5'h00, 2'h0);
        xfer(1'b0, pil_pkg::OFS_SOFT, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, pil_pkg::OFS_COMPARE, 32'h0, 32'hFFFF_FFFF, 1'b0);
        xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        xfer(1'b1, pil_pkg::OFS_CAUSE, 32'hFFFF_FFFF, 32'h0, 1'b0);
        st(1'b0, 5'h00, 2'h0);
        $display("test reset done");
        for (k = 0; k < 5; k++) begin
            i_pil_agent.send(4'h4, 5'h1F, 5'h01 << k, 1'b1);
            st(1'b0, 5'h01 << k, 2'h0);
        end
        i_pil_agent.send(4'h4, 5'h1F, 5'h15, 1'b1);
        st(1'b0, 5'h15, 2'h0);
        i_pil_agent.send(4'hB, 5'h1F, 5'h00, 1'b1);
        st(1'b0, 5'h15, 2'h0);
        i_pil_agent.send(4'hF, 5'h03, 5'h02, 1'b0);
        i_pil_agent.send(4'h4, 5'h10, 5'h00, 1'b1);
        st(1'b0, 5'h06, 2'h0);
        i_pil_agent.send(4'h4, 5'h1F, 5'h00, 1'b1);
        st(1'b0, 5'h00, 2'h0);
        $display("test hardware done");
        xfer(1'b1, pil_pkg::OFS_SOFT, 32'h3, 32'h0, 1'b0);
        st(1'b0, 5'h00, 2'h3);
        xfer(1'b1, pil_pkg::OFS_SOFT, 32'h1, 32'h0, 1'b0);
        st(1'b0, 5'h00, 2'h1);
        $display("test software done");
        xfer(1'b1, pil_pkg::OFS_COUNT, 32'h100, 32'h0, 1'b0);
        xfer(1'b0, pil_pkg::OFS_COUNT, 32'h0, 32'h101, 1'b0);
        xfer(1'b1, pil_pkg::OFS_COMPARE, 32'h140, 32'h0, 1'b0);
        st(1'b0, 5'h00, 2'h1);
        for (k = 0; k < 300 && cause[15] !== 1'b1; k++) @(posedge mclk_i);
        chk(k < 300, 32'h1);
        st(1'b1, 5'h00, 2'h1);
        for (k = 0; k < 2; k++) begin
            xfer(1'b1, pil_pkg::OFS_COMPARE, 32'hFFFF_FFFF, 32'h0, 1'b0);
            st(1'b0, 5'h00, 2'h1);
            perf_ovf <= (k == 0) ? 2'h1 : 2'h2;
            @(posedge mclk_i);
            perf_ovf <= 2'h0;
            st(1'b1, 5'h00, 2'h1);
        end
        $display("test timer done");
        i_pil_agent.set_nmi(1'b0);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, nmi_pulse}, 32'h1);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, nmi_pulse}, 32'h0);
        i_pil_agent.set_nmi(1'b1);
        @(posedge mclk_i);
        i_pil_agent.set_nmi(1'b0);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, nmi_pulse}, 32'h1);
        i_pil_agent.set_nmi(1'b1);
        @(posedge mclk_i);
        // Frozen: update cycle and pin fall must leave no trace until enabled
        clk_en <= 1'b0;
        i_pil_agent.send(4'h4, 5'h1F, 5'h0A, 1'b1);
        i_pil_agent.set_nmi(1'b0);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, nmi_pulse}, 32'h0);
        clk_en <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk({31'h0, nmi_pulse}, 32'h1);
        i_pil_agent.set_nmi(1'b1);
        st(1'b1, 5'h00, 2'h1);
        $display("test nonmaskable done");
        i_pil_agent.send(4'h4, 5'h1F, 5'h1F, 1'b1);
        st(1'b1, 5'h1F, 2'h1);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        st(1'b0, 5'h00, 2'h0);
        $display("test reset again done");
        conclude();
    end
endmodule
